// ==== core/debug_support_pkg.sv ====
// Purpose: Shared constants for the debug support unit
// Assumes: Byte-wide registers selected by a small index on the peripheral port
// Notes: Bus status codes are the encodings driven to the emulator
package debug_support_pkg;
  // Register indexes on the peripheral port
  localparam logic [1:0] IDX_DEBUG_CONFIG = 2'h0;
  localparam logic [1:0] IDX_DEBUG_FREEZE_ENABLE = 2'h1;
  // Field positions
  localparam int CFG_ON_BIT = 0;
  localparam int CFG_FREEZE_BIT = 1;
  localparam int FEN_TIMER_BIT = 0;
  localparam int FEN_TWOWIRE_BIT = 1;
  // Reset values
  localparam logic [7:0] DEBUG_CONFIG_RESET = 8'h00;
  localparam logic [7:0] DEBUG_FREEZE_ENABLE_RESET = 8'h00;
  // Core bus status codes
  localparam logic [2:0] BST_NOT_T1 = 3'h0;
  localparam logic [2:0] BST_WAIT = 3'h1;
  localparam logic [2:0] BST_INT_ACK = 3'h2;
  localparam logic [2:0] BST_NONCORE_DATA = 3'h3;
  localparam logic [2:0] BST_SEQ_FETCH = 3'h4;
  localparam logic [2:0] BST_NONSEQ_FETCH = 3'h5;
  localparam logic [2:0] BST_CORE_DATA = 3'h6;
  localparam logic [2:0] BST_EXCEPTION = 3'h7;
  // Address zones of a transaction
  localparam logic [1:0] ZONE_ONCHIP = 2'h0;
  localparam logic [1:0] ZONE_EXT_MEMORY = 2'h1;
  localparam logic [1:0] ZONE_BASE_MEMORY = 2'h2;
  localparam logic [1:0] ZONE_IO_EXPANSION = 2'h3;
  // Supervisory timer timeout in clock cycles
  localparam int WDT_TIMEOUT_CYCLES = 1024;
  localparam int WDT_COUNT_WIDTH = 16;
  // Monitoring address width
  localparam int MON_ADDR_WIDTH = 13;
endpackage : debug_support_pkg

// ==== core/supervisory_timer.sv ====
// Purpose: Supervisory timer counter with debug freeze
// Assumes: Refresh is a one-cycle pulse from software
// Notes: A pending timeout finishes its reset even while frozen
`timescale 1ns/1ps
module supervisory_timer #(
  parameter int TIMEOUT = debug_support_pkg::WDT_TIMEOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic freeze,
  input wire logic refresh,
  output logic [debug_support_pkg::WDT_COUNT_WIDTH-1:0] count,
  output logic timeout_irq,
  output logic timer_reset
);
  localparam logic [debug_support_pkg::WDT_COUNT_WIDTH-1:0] RELOAD =
    debug_support_pkg::WDT_COUNT_WIDTH'(TIMEOUT - 1);
  logic [debug_support_pkg::WDT_COUNT_WIDTH-1:0] count_r;
  logic pending_r;
  logic irq_r;
  logic reset_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
      count_r <= RELOAD;
    else if (refresh)
      count_r <= RELOAD;
    else if (!freeze && count_r != '0)
      count_r <= count_r - 1'b1;
  end

  // Timeout is only raised while running; its reset ignores freeze
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      pending_r <= 1'b0;
      reset_r <= 1'b0;
    end
    else
    begin
      // A one-cycle pulse; the pending flag is still clear on the cycle after the raise
      irq_r <= !freeze && !refresh && count_r == '0 && !pending_r && !irq_r;
      if (irq_r)
        pending_r <= 1'b1;
      else if (reset_r)
        pending_r <= 1'b0;
      reset_r <= pending_r && !reset_r;
    end
  end

  assign count = count_r;
  assign timeout_irq = irq_r;
  assign timer_reset = reset_r;

  property p_hold_when_frozen;
    @(posedge mclk) disable iff (rst)
    (freeze && !refresh) |=> (count_r == $past(count_r));
  endproperty
  a_hold_when_frozen: assert property (p_hold_when_frozen) else $error("timer moved while frozen");

  property p_reset_despite_freeze;
    @(posedge mclk) disable iff (rst)
    irq_r |=> ##1 reset_r;
  endproperty
  a_reset_despite_freeze: assert property (p_reset_despite_freeze) else $error("timeout reset not taken");
endmodule : supervisory_timer

// ==== core/debug_support_unit.sv ====
// Purpose: Debug support: emulator interrupt, strap, freeze control, core activity monitor
// Assumes: All inputs synchronous to mclk; registers reached by index on the peripheral port
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module debug_support_unit #(
  parameter int WDT_TIMEOUT = debug_support_pkg::WDT_TIMEOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic dev_environment,
  input wire logic [1:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic emulator_irq_n,
  output logic emulator_nmi,
  input wire logic output_float_strap,
  output logic output_float,
  output logic wdt_freeze,
  output logic timer_freeze,
  output logic twowire_freeze,
  input wire logic wdt_refresh,
  output logic wdt_timeout_irq,
  output logic wdt_reset,
  input wire logic periph_rd_destructive,
  input wire logic periph_rd_nmi_status,
  input wire logic periph_rd_rtc,
  input wire logic periph_rd_host,
  output logic periph_rd_side_effect,
  input wire logic psr_wr,
  input wire logic psr_local_in,
  input wire logic psr_global_in,
  input wire logic trap_taken,
  input wire logic irq_taken,
  output logic local_irq_enable,
  output logic global_irq_enable,
  output logic maskable_irq_allowed,
  input wire logic txn_start,
  input wire logic [1:0] txn_zone,
  input wire logic [debug_support_pkg::MON_ADDR_WIDTH-1:0] txn_addr,
  input wire logic txn_byte,
  input wire logic txn_read,
  input wire logic txn_fetch,
  input wire logic txn_seq,
  input wire logic txn_core_data,
  input wire logic txn_exception,
  input wire logic txn_int_ack,
  input wire logic txn_ext8_word,
  input wire logic core_waiting,
  input wire logic instr_done,
  input wire logic instr_long,
  input wire logic instr_flush,
  output logic fetch_hold,
  output logic [2:0] core_bus_status,
  output logic [debug_support_pkg::MON_ADDR_WIDTH-1:0] mon_addr,
  output logic byte_lane_low,
  output logic byte_lane_high,
  output logic core_bus_read,
  output logic mon_cycle,
  output logic ext_cycle,
  output logic ext_memory_select,
  output logic base_memory_select,
  output logic io_expansion_select,
  output logic pipe_flow,
  output logic pipe_long_instr,
  output logic mon_oe
);
  typedef enum logic [0:0] {MON_IDLE, MON_SECOND} mon_state_type;

  logic [7:0] cfg_r;
  logic [7:0] fen_r;
  logic [7:0] rdata_r;
  logic irq_prev_r;
  logic nmi_r;
  logic strap_done_r;
  logic float_r;
  logic local_ie_r;
  logic global_ie_r;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [debug_support_pkg::MON_ADDR_WIDTH-1:0] addr_r;
  logic lane_low_r;
  logic lane_high_r;
  logic read_r;
  logic mon_cycle_r;
  logic ext_cycle_r;
  logic sel_ext_r;
  logic sel_base_r;
  logic sel_io_r;
  logic pfs_r;
  logic pli_r;
  mon_state_type mon_state_r;
  logic debug_on;
  logic freeze_on;

  // Register file
  // Debug-on only survives in the development environment
  assign debug_on = cfg_r[debug_support_pkg::CFG_ON_BIT] & dev_environment;
  assign freeze_on = debug_on & cfg_r[debug_support_pkg::CFG_FREEZE_BIT];

  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_r <= debug_support_pkg::DEBUG_CONFIG_RESET;
    else if (reg_wr && reg_index == debug_support_pkg::IDX_DEBUG_CONFIG)
    begin
      cfg_r[debug_support_pkg::CFG_ON_BIT] <= reg_wdata[debug_support_pkg::CFG_ON_BIT] & dev_environment;
      cfg_r[debug_support_pkg::CFG_FREEZE_BIT] <= reg_wdata[debug_support_pkg::CFG_FREEZE_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      fen_r <= debug_support_pkg::DEBUG_FREEZE_ENABLE_RESET;
    else if (reg_wr && reg_index == debug_support_pkg::IDX_DEBUG_FREEZE_ENABLE)
    begin
      fen_r[debug_support_pkg::FEN_TIMER_BIT] <= reg_wdata[debug_support_pkg::FEN_TIMER_BIT];
      fen_r[debug_support_pkg::FEN_TWOWIRE_BIT] <= reg_wdata[debug_support_pkg::FEN_TWOWIRE_BIT];
    end
  end

  // Reserved bits are never stored, so they read as zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_index)
        debug_support_pkg::IDX_DEBUG_CONFIG:
          rdata_r <= {cfg_r[7:1], debug_on};
        debug_support_pkg::IDX_DEBUG_FREEZE_ENABLE:
          rdata_r <= fen_r;
        default:
          rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  // Emulator interrupt
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_prev_r <= 1'b1;
      nmi_r <= 1'b0;
    end
    else
    begin
      irq_prev_r <= emulator_irq_n;
      nmi_r <= irq_prev_r && !emulator_irq_n && debug_on;
    end
  end
  assign emulator_nmi = nmi_r;

  // Strap caught on the first edge after reset release, never during reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      strap_done_r <= 1'b0;
      float_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      float_r <= output_float_strap;
    end
  end
  assign output_float = float_r;
  assign mon_oe = !float_r;

  // Freeze distribution
  assign wdt_freeze = freeze_on;
  assign timer_freeze = freeze_on & fen_r[debug_support_pkg::FEN_TIMER_BIT];
  assign twowire_freeze = freeze_on & fen_r[debug_support_pkg::FEN_TWOWIRE_BIT];
  // Exempt read sources keep their side effects so status is not lost
  assign periph_rd_side_effect = periph_rd_destructive &
    (!freeze_on | periph_rd_nmi_status | periph_rd_rtc | periph_rd_host);

  supervisory_timer #(
    .TIMEOUT(WDT_TIMEOUT)
  ) u_wdt (
    .mclk(mclk),
    .rst(rst),
    .freeze(freeze_on),
    .refresh(wdt_refresh),
    .count(),
    .timeout_irq(wdt_timeout_irq),
    .timer_reset(wdt_reset)
  );

  // Core interrupt enables; auto-clear beats a simultaneous write
  always_ff @(posedge mclk)
  begin
    if (rst)
      local_ie_r <= 1'b0;
    else if (trap_taken || irq_taken)
      local_ie_r <= 1'b0;
    else if (psr_wr)
      local_ie_r <= psr_local_in;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      global_ie_r <= 1'b0;
    else if (psr_wr)
      global_ie_r <= psr_global_in;
  end
  assign local_irq_enable = local_ie_r;
  assign global_irq_enable = global_ie_r;
  assign maskable_irq_allowed = local_ie_r & global_ie_r;

  // Bus status encoding
  always_comb
  begin
    status_nxt = debug_support_pkg::BST_NOT_T1;
    if (txn_start)
    begin
      if (txn_int_ack)
        status_nxt = debug_support_pkg::BST_INT_ACK;
      else if (txn_fetch)
        status_nxt = txn_seq ? debug_support_pkg::BST_SEQ_FETCH : debug_support_pkg::BST_NONSEQ_FETCH;
      else if (txn_exception)
        status_nxt = debug_support_pkg::BST_EXCEPTION;
      else if (txn_core_data)
        status_nxt = debug_support_pkg::BST_CORE_DATA;
      else
        status_nxt = debug_support_pkg::BST_NONCORE_DATA;
    end
    else if (mon_state_r == MON_SECOND)
      status_nxt = debug_support_pkg::BST_NOT_T1;
    else if (core_waiting)
      status_nxt = debug_support_pkg::BST_WAIT;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      status_r <= debug_support_pkg::BST_NOT_T1;
    else
      status_r <= status_nxt;
  end
  assign core_bus_status = status_r;

  // Second external cycle of a word to 8-bit external memory; core holds off a new start meanwhile
  always_ff @(posedge mclk)
  begin
    if (rst)
      mon_state_r <= MON_IDLE;
    else
    begin
      case (mon_state_r)
        MON_IDLE:
          if (txn_start && txn_ext8_word && txn_zone == debug_support_pkg::ZONE_EXT_MEMORY)
            mon_state_r <= MON_SECOND;
        MON_SECOND:
          mon_state_r <= MON_IDLE;
        default:
          mon_state_r <= MON_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ext_cycle_r <= 1'b0;
    else
      ext_cycle_r <= (txn_start && txn_zone != debug_support_pkg::ZONE_ONCHIP) || mon_state_r == MON_SECOND;
  end
  assign ext_cycle = ext_cycle_r;

  // Transaction description, held until the next start
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      addr_r <= '0;
      lane_low_r <= 1'b0;
      lane_high_r <= 1'b0;
      read_r <= 1'b0;
      sel_ext_r <= 1'b0;
      sel_base_r <= 1'b0;
      sel_io_r <= 1'b0;
    end
    else if (txn_start)
    begin
      addr_r <= txn_addr;
      lane_low_r <= !txn_byte || !txn_addr[0];
      lane_high_r <= !txn_byte || txn_addr[0];
      read_r <= txn_read;
      sel_ext_r <= txn_zone == debug_support_pkg::ZONE_EXT_MEMORY;
      sel_base_r <= txn_zone == debug_support_pkg::ZONE_BASE_MEMORY;
      sel_io_r <= txn_zone == debug_support_pkg::ZONE_IO_EXPANSION;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      mon_cycle_r <= 1'b0;
    else
      mon_cycle_r <= txn_start && txn_zone == debug_support_pkg::ZONE_ONCHIP;
  end
  assign mon_addr = addr_r;
  assign byte_lane_low = lane_low_r;
  assign byte_lane_high = lane_high_r;
  assign core_bus_read = read_r;
  assign mon_cycle = mon_cycle_r;
  assign ext_memory_select = sel_ext_r;
  assign base_memory_select = sel_base_r;
  assign io_expansion_select = sel_io_r;

  // Pipe status
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pfs_r <= 1'b0;
      pli_r <= 1'b0;
    end
    else
    begin
      pfs_r <= instr_done;
      pli_r <= instr_done && instr_long;
    end
  end
  assign pipe_flow = pfs_r;
  assign pipe_long_instr = pli_r;
  // Holding the fetch one cycle keeps its status behind the pipe-flow mark
  assign fetch_hold = instr_done & instr_flush;

  property p_nmi_on_edge;
    @(posedge mclk) disable iff (rst)
    ($fell(emulator_irq_n) && debug_on) |=> emulator_nmi;
  endproperty
  a_nmi_on_edge: assert property (p_nmi_on_edge) else $error("emulator edge gave no nmi");

  property p_nmi_ignored_off;
    @(posedge mclk) disable iff (rst)
    !debug_on |=> !emulator_nmi;
  endproperty
  a_nmi_ignored_off: assert property (p_nmi_ignored_off) else $error("nmi while debug off");

  property p_on_reads_zero;
    @(posedge mclk) disable iff (rst)
    (reg_rd && reg_index == debug_support_pkg::IDX_DEBUG_CONFIG && !dev_environment) |=> !reg_rdata[0];
  endproperty
  a_on_reads_zero: assert property (p_on_reads_zero) else $error("debug-on read as one");

  property p_freeze_needs_on;
    @(posedge mclk) disable iff (rst)
    !debug_on |-> !(wdt_freeze || timer_freeze || twowire_freeze) && (periph_rd_side_effect == periph_rd_destructive);
  endproperty
  a_freeze_needs_on: assert property (p_freeze_needs_on) else $error("freeze acted with debug off");

  property p_nmi_status_exempt;
    @(posedge mclk) disable iff (rst)
    (periph_rd_destructive && periph_rd_nmi_status) |-> periph_rd_side_effect;
  endproperty
  a_nmi_status_exempt: assert property (p_nmi_status_exempt) else $error("status read effect lost");

  property p_irq_clears_local;
    @(posedge mclk) disable iff (rst)
    (trap_taken || irq_taken) |=> !local_irq_enable && !maskable_irq_allowed;
  endproperty
  a_irq_clears_local: assert property (p_irq_clears_local) else $error("local enable not cleared");

  property p_int_ack_code;
    @(posedge mclk) disable iff (rst)
    (txn_start && txn_int_ack) |=> core_bus_status == 3'h2;
  endproperty
  a_int_ack_code: assert property (p_int_ack_code) else $error("bad interrupt ack status");

  property p_ext8_second;
    @(posedge mclk) disable iff (rst)
    (txn_start && txn_ext8_word && txn_zone == debug_support_pkg::ZONE_EXT_MEMORY && mon_state_r == MON_IDLE)
      |=> ext_cycle ##1 (ext_cycle && core_bus_status == 3'h0);
  endproperty
  a_ext8_second: assert property (p_ext8_second) else $error("second cycle wrong");

  property p_byte_lanes;
    @(posedge mclk) disable iff (rst)
    (txn_start && txn_byte) |=> (byte_lane_low != byte_lane_high) && (byte_lane_high == mon_addr[0]);
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lane mismatch");

  property p_pipe_flow;
    @(posedge mclk) disable iff (rst)
    instr_done |=> pipe_flow && (pipe_long_instr == $past(instr_long));
  endproperty
  a_pipe_flow: assert property (p_pipe_flow) else $error("pipe status wrong");
endmodule : debug_support_unit

// ==== verification/emulator_model.sv ====
// Purpose: Emulator side: drives the interrupt pin and counts answers
// Assumes: Pin idles high; strike is a one-cycle request
// Notes: Two low cycles give the edge detector a clean edge
`timescale 1ns/1ps
module emulator_model (
  input wire logic mclk,
  input wire logic strike,
  input wire logic emulator_nmi,
  output logic emulator_irq_n,
  output int nmi_count
);
  int low_cnt;
  always @(posedge mclk)
  begin
    if (strike)
      low_cnt <= 2;
    else if (low_cnt > 0)
      low_cnt <= low_cnt - 1;
    if (emulator_nmi === 1'b1)
      nmi_count <= nmi_count + 1;
  end
  // Changes away from the sampling edge so the pin never races the design
  always @(negedge mclk)
    emulator_irq_n <= (low_cnt == 0);
endmodule : emulator_model

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the debug support unit
// Assumes: Inputs change at the falling edge; timer shortened to 16
// Notes: Register reads are noted in a queue and checked by a watcher
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst, dev_environment, reg_wr, reg_rd, emulator_irq_n, emulator_nmi;
  logic [1:0] reg_index, txn_zone;
  logic [7:0] reg_wdata, reg_rdata;
  logic output_float_strap, output_float, wdt_freeze, timer_freeze, twowire_freeze;
  logic wdt_refresh, wdt_timeout_irq, wdt_reset, periph_rd_destructive, periph_rd_nmi_status;
  logic periph_rd_rtc, periph_rd_host, periph_rd_side_effect, psr_wr, psr_local_in, psr_global_in;
  logic trap_taken, irq_taken, local_irq_enable, global_irq_enable, maskable_irq_allowed;
  logic txn_start, txn_byte, txn_read, txn_fetch, txn_seq, txn_core_data, txn_exception;
  logic txn_int_ack, txn_ext8_word, core_waiting, instr_done, instr_long, instr_flush, fetch_hold;
  logic [2:0] core_bus_status;
  logic [debug_support_pkg::MON_ADDR_WIDTH-1:0] txn_addr, mon_addr;
  logic byte_lane_low, byte_lane_high, core_bus_read, mon_cycle, ext_cycle, mon_oe;
  logic ext_memory_select, base_memory_select, io_expansion_select, pipe_flow, pipe_long_instr;
  logic strike, rd_seen, frz;
  int nmi_count, mismatches, cmp_count, irq_seen, n0, k, i;
  logic [7:0] exp_q[$];
  logic [2:0] codes[6] = '{3'h2, 3'h5, 3'h4, 3'h6, 3'h7, 3'h3};

  debug_support_unit #(.WDT_TIMEOUT(16)) debug_support_unit_i (.*);
  emulator_model emulator_model_i (.mclk(mclk), .strike(strike), .emulator_nmi(emulator_nmi),
    .emulator_irq_n(emulator_irq_n), .nmi_count(nmi_count));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task report_and_stop;
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic wait_hi(ref logic s, input int n);
    for (int j = 0; j < n && s !== 1'b1; j++)
      @(negedge mclk);
    if (s !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_hi

  task wr(input logic [1:0] idx, input logic [7:0] d);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // One idle edge so a following call never re-raises the strobe in this step
    @(negedge mclk);
  endtask : wr

  task rd(input logic [1:0] idx, input logic [7:0] e);
    reg_index = idx;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
  endtask : rd

  // Read data stands one cycle after the strobe
  always @(posedge mclk)
    rd_seen <= reg_rd;
  always @(negedge mclk)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      check8(reg_rdata, exp_q.pop_front());
  always @(posedge mclk)
    if (wdt_timeout_irq === 1'b1)
      irq_seen <= irq_seen + 1;

  initial
  begin
    #2000000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    {dev_environment, reg_wr, reg_rd, reg_index, reg_wdata, output_float_strap, wdt_refresh} = '0;
    {periph_rd_destructive, periph_rd_nmi_status, periph_rd_rtc, periph_rd_host, psr_wr} = '0;
    {psr_local_in, psr_global_in, trap_taken, irq_taken, txn_start, txn_zone, txn_addr} = '0;
    {txn_byte, txn_read, txn_fetch, txn_seq, txn_core_data, txn_exception, txn_int_ack} = '0;
    {txn_ext8_word, core_waiting, instr_done, instr_long, instr_flush, strike} = '0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'hE398ED57));
    rst = 1'b1;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'h02);
    n0 = nmi_count;
    strike = 1'b1;
    @(negedge mclk);
    strike = 1'b0;
    repeat (4) @(negedge mclk);
    check8(nmi_count[7:0], n0[7:0]);
    dev_environment = 1'b1;
    wr(2'h0, 8'h01);
    wr(2'h1, 8'h03);
    rd(2'h0, 8'h01);
    rd(2'h1, 8'h03);
    strike = 1'b1;
    @(negedge mclk);
    strike = 1'b0;
    repeat (4) @(negedge mclk);
    check8(nmi_count[7:0], n0[7:0] + 8'h01);
    // Destructive reads with freeze off, then on; timer test enters with freeze set
    for (k = 0; k < 2; k++)
    begin
      wr(2'h0, k ? 8'h03 : 8'h01);
      frz = (k == 1);
      @(negedge mclk);
      check8({5'h00, wdt_freeze, timer_freeze, twowire_freeze}, {5'h00, {3{frz}}});
      for (i = 0; i < 8; i++)
      begin
        {periph_rd_nmi_status, periph_rd_rtc, periph_rd_host} = 3'($urandom);
        periph_rd_destructive = 1'b1;
        #1;
        check8({7'h00, periph_rd_side_effect},
          {7'h00, !frz || periph_rd_nmi_status || periph_rd_rtc || periph_rd_host});
        @(negedge mclk);
      end
      periph_rd_destructive = 1'b0;
    end
    wr(2'h1, 8'h01);
    @(negedge mclk);
    check8({6'h00, timer_freeze, twowire_freeze}, 8'h02);
    wdt_refresh = 1'b1;
    @(negedge mclk);
    wdt_refresh = 1'b0;
    n0 = irq_seen;
    repeat (40) @(negedge mclk);
    check8(irq_seen[7:0], n0[7:0]);
    wr(2'h0, 8'h01);
    wait_hi(wdt_timeout_irq, 20);
    wr(2'h0, 8'h03);
    wait_hi(wdt_reset, 4);
    wr(2'h0, 8'h00);
    for (k = 0; k < 6; k++)
    begin
      {txn_int_ack, txn_fetch, txn_seq} = {k == 0, k == 1 || k == 2, k == 2};
      {txn_core_data, txn_exception} = {k == 3, k == 4};
      txn_zone = 2'($urandom);
      txn_addr = 13'($urandom);
      {txn_byte, txn_read} = 2'($urandom);
      txn_start = 1'b1;
      @(negedge mclk);
      txn_start = 1'b0;
      check8({5'h00, core_bus_status}, {5'h00, codes[k]});
      check8({5'h00, byte_lane_low, byte_lane_high, core_bus_read},
        {5'h00, !txn_byte || !txn_addr[0], !txn_byte || txn_addr[0], txn_read});
      check8({4'h0, mon_cycle, ext_memory_select, base_memory_select, io_expansion_select},
        {4'h0, txn_zone == 2'h0, txn_zone == 2'h1, txn_zone == 2'h2, txn_zone == 2'h3});
      check8(mon_addr[7:0], txn_addr[7:0]);
      check8({3'h0, mon_addr[12:8]}, {3'h0, txn_addr[12:8]});
      @(negedge mclk);
    end
    {txn_zone, txn_byte, txn_ext8_word, txn_core_data} = {2'h1, 1'b0, 1'b1, 1'b1};
    {txn_fetch, txn_seq, txn_start} = 3'h1;
    @(negedge mclk);
    txn_start = 1'b0;
    check8({4'h0, ext_cycle, core_bus_status}, 8'h0E);
    @(negedge mclk);
    check8({4'h0, ext_cycle, core_bus_status}, 8'h08);
    txn_ext8_word = 1'b0;
    core_waiting = 1'b1;
    repeat (2) @(negedge mclk);
    check8({5'h00, core_bus_status}, 8'h01);
    core_waiting = 1'b0;
    for (k = 0; k < 2; k++)
    begin
      {instr_done, instr_long, instr_flush} = {1'b1, k == 1, k == 0};
      #1;
      check8({7'h00, fetch_hold}, {7'h00, k == 0});
      @(negedge mclk);
      instr_done = 1'b0;
      check8({6'h00, pipe_flow, pipe_long_instr}, {6'h00, 1'b1, k == 1});
      @(negedge mclk);
    end
    {psr_wr, psr_local_in, psr_global_in} = 3'h7;
    @(negedge mclk);
    psr_wr = 1'b0;
    check8({6'h00, global_irq_enable, maskable_irq_allowed}, 8'h03);
    trap_taken = 1'b1;
    @(negedge mclk);
    trap_taken = 1'b0;
    check8({6'h00, local_irq_enable, maskable_irq_allowed}, 8'h00);
    {psr_wr, psr_global_in} = 2'h2;
    @(negedge mclk);
    {psr_wr, irq_taken} = 2'h1;
    check8({5'h00, global_irq_enable, local_irq_enable, maskable_irq_allowed}, 8'h02);
    @(negedge mclk);
    irq_taken = 1'b0;
    check8({7'h00, local_irq_enable}, 8'h00);
    output_float_strap = 1'b1;
    rst = 1'b1;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    check8({6'h00, output_float, mon_oe}, 8'h02);
    rd(2'h0, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
